// ==== shared/mse_map.svh ====
`ifndef MSE_MAP_SVH
`define MSE_MAP_SVH
`define MSE_MIN_FRAME_LEN      16'h0040
`define MSE_BIN_127_LEN        16'h007F
`define MSE_BIN_255_LEN        16'h00FF
`define MSE_BIN_511_LEN        16'h01FF
`define MSE_BIN_1023_LEN       16'h03FF
`define MSE_BIN_1518_LEN       16'h05EE
`define MSE_RX_MAX_SIZE_RESET  16'h05EE
`define MSE_BIN_COUNT          6
`endif

// ==== shared/mse_pkg.sv ====
`default_nettype none
package mse_pkg;
    typedef enum logic [1:0] {
        MSE_DEST_UCAST,
        MSE_DEST_MCAST,
        MSE_DEST_BCAST
    } mse_dest_type;
endpackage : mse_pkg
`default_nettype wire

// ==== shared/mse_frame_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface mse_frame_if;
    logic                   done;
    logic [15:0]            frame_len;
    logic [15:0]            payload_len;
    logic                   fcs_err;
    logic                   len_err;
    logic                   oversize;
    logic                   undersize;
    modport src (output done, frame_len, payload_len, fcs_err, len_err, oversize, undersize);
    modport dst (input  done, frame_len, payload_len, fcs_err, len_err, oversize, undersize);
endinterface : mse_frame_if
`default_nettype wire

// ==== logic/mse_octet_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
module mse_octet_counter #(
    parameter int TOTAL_W = 64
) (
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    mse_frame_if.dst                frm,
    output logic [15:0]             bytes_out,
    output logic                    strobe_out,
    output logic [TOTAL_W-1:0]      total_out
);
    logic qualify;
    assign qualify = frm.done && !frm.fcs_err && !frm.oversize && !frm.undersize && !frm.len_err;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strobe_out <= 1'b0;
            bytes_out  <= 16'h0000;
        end else begin
            strobe_out <= qualify;
            if (qualify) begin
                bytes_out <= frm.payload_len;
            end
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            total_out <= '0;
        end else if (qualify) begin
            total_out <= total_out + TOTAL_W'(frm.payload_len);
        end
    end
endmodule : mse_octet_counter
`default_nettype wire

// ==== logic/mse_tx_side.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mse_map.svh"
module mse_tx_side (
    input  wire logic        clk_txmac_in,
    input  wire logic        rst_n_in,
    input  wire logic        tx_done_in,
    input  wire logic [15:0] tx_frame_len_in,
    input  wire logic [15:0] tx_payload_len_in,
    input  wire logic        tx_fcs_err_in,
    input  wire logic        tx_len_err_in,
    input  wire logic [15:0] tx_max_size_in,
    output logic             tx_inc_sizeok_fcserr_out,
    output logic [15:0]      tx_frame_payload_bytes_out,
    output logic             tx_frame_payload_strobe_out,
    output logic [63:0]      tx_payload_total_counter_out
);
    mse_frame_if tf ();
    assign tf.done        = tx_done_in;
    assign tf.frame_len   = tx_frame_len_in;
    assign tf.payload_len = tx_payload_len_in;
    assign tf.fcs_err     = tx_fcs_err_in;
    assign tf.len_err     = tx_len_err_in;
    assign tf.oversize    = tx_frame_len_in > tx_max_size_in;
    assign tf.undersize   = tx_frame_len_in < `MSE_MIN_FRAME_LEN;
    always_ff @(posedge clk_txmac_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_inc_sizeok_fcserr_out <= 1'b0;
        end else begin
            tx_inc_sizeok_fcserr_out <= tf.done && tf.fcs_err && !tf.oversize && !tf.undersize;
        end
    end
    mse_octet_counter #(.TOTAL_W(64)) u_tx_oct (
        .clk_in     (clk_txmac_in),
        .rst_n_in   (rst_n_in),
        .frm        (tf.dst),
        .bytes_out  (tx_frame_payload_bytes_out),
        .strobe_out (tx_frame_payload_strobe_out),
        .total_out  (tx_payload_total_counter_out)
    );
endmodule : mse_tx_side
`default_nettype wire

// ==== logic/mse_stats_events.sv ====
// Behaviour
// - tx size-ok fcs-error pulses one tx cycle for valid-length fcs-errored frame.
// - rx runt pulses one cycle per runt packet.
// - exactly one rx length bin pulses per in-range frame.
// - rx max pulses when length equals programmed maximum.
// - rx over pulses when length exceeds programmed maximum.
// - errored non-control rx frame pulses its destination-class data error output.
// - good non-control rx frame pulses its destination-class data ok output.
// - valid rx control frame pulses its destination-class control output.
// - valid rx pause frame pulses rx pause.
// - rx fcs error pulses for any fcs-errored packet.
// - rx fragment pulses for sub-64-byte frame with crc error.
// - rx jabber pulses for oversize frame with crc error.
// - rx size-ok fcs-error pulses for valid-length frame with fcs error.
// - rx pause error pulses for errored pause frame.
// - errored rx control frame pulses its destination-class control error output.
// - two 64-bit cumulative payload counters, rx and tx, qualifying frames only.
// - each direction gives 16-bit per-frame payload count and valid pulse.
// - count valid pulses only for frames free of all listed errors.
// - count outputs driven regardless of statistics counter build option.
// - rx count on rx mac clock, tx count on tx mac clock.
// - rx pulses on rx mac clock, tx pulses on tx mac clock.
// - increment pulses driven regardless of statistics counter build option.
`timescale 1ns/10ps
`default_nettype none
`include "mse_map.svh"
module mse_stats_events (
    input  wire logic                 clk_rxmac_in,
    input  wire logic                 rst_rx_n_in,
    input  wire logic                 clk_txmac_in,
    input  wire logic                 rst_tx_n_in,
    input  wire logic                 rx_done_in,
    input  wire logic [15:0]          rx_frame_len_in,
    input  wire logic [15:0]          rx_payload_len_in,
    input  wire logic                 rx_fcs_err_in,
    input  wire logic                 rx_len_err_in,
    input  wire logic                 rx_ctrl_in,
    input  wire logic                 rx_pause_in,
    input  wire logic [1:0]           rx_dest_in,
    input  wire logic [15:0]          rx_max_size_in,
    input  wire logic                 tx_done_in,
    input  wire logic [15:0]          tx_frame_len_in,
    input  wire logic [15:0]          tx_payload_len_in,
    input  wire logic                 tx_fcs_err_in,
    input  wire logic                 tx_len_err_in,
    input  wire logic [15:0]          tx_max_size_in,
    output logic                      tx_inc_sizeok_fcserr_out,
    output logic [15:0]               tx_frame_payload_bytes_out,
    output logic                      tx_frame_payload_strobe_out,
    output logic [63:0]               tx_payload_total_counter_out,
    output logic                      rx_inc_runt_out,
    output logic [5:0]                rx_inc_bin_out,
    output logic                      rx_inc_max_out,
    output logic                      rx_inc_over_out,
    output logic                      rx_inc_mcast_data_err_out,
    output logic                      rx_inc_mcast_data_ok_out,
    output logic                      rx_inc_bcast_data_err_out,
    output logic                      rx_inc_bcast_data_ok_out,
    output logic                      rx_inc_ucast_data_err_out,
    output logic                      rx_inc_ucast_data_ok_out,
    output logic                      rx_inc_mcast_ctrl_out,
    output logic                      rx_inc_bcast_ctrl_out,
    output logic                      rx_inc_ucast_ctrl_out,
    output logic                      rx_inc_pause_out,
    output logic                      rx_inc_fcs_err_out,
    output logic                      rx_inc_fragment_out,
    output logic                      rx_inc_jabber_out,
    output logic                      rx_inc_sizeok_fcserr_out,
    output logic                      rx_inc_pause_ctrl_err_out,
    output logic                      rx_inc_mcast_ctrl_err_out,
    output logic                      rx_inc_bcast_ctrl_err_out,
    output logic                      rx_inc_ucast_ctrl_err_out,
    output logic [15:0]               rx_frame_payload_bytes_out,
    output logic                      rx_frame_payload_strobe_out,
    output logic [63:0]               rx_payload_total_counter_out
);
    // tx side lives entirely on the tx mac clock
    mse_tx_side u_tx (
        .clk_txmac_in                 (clk_txmac_in),
        .rst_n_in                     (rst_tx_n_in),
        .tx_done_in                   (tx_done_in),
        .tx_frame_len_in              (tx_frame_len_in),
        .tx_payload_len_in            (tx_payload_len_in),
        .tx_fcs_err_in                (tx_fcs_err_in),
        .tx_len_err_in                (tx_len_err_in),
        .tx_max_size_in               (tx_max_size_in),
        .tx_inc_sizeok_fcserr_out     (tx_inc_sizeok_fcserr_out),
        .tx_frame_payload_bytes_out   (tx_frame_payload_bytes_out),
        .tx_frame_payload_strobe_out  (tx_frame_payload_strobe_out),
        .tx_payload_total_counter_out (tx_payload_total_counter_out)
    );

    mse_frame_if rf ();
    logic over;
    logic under;
    logic bad;
    logic is_m;
    logic is_b;
    logic is_u;
    logic [5:0] bin_d;

    assign over  = rx_frame_len_in > rx_max_size_in;
    assign under = rx_frame_len_in < `MSE_MIN_FRAME_LEN;
    assign bad   = rx_fcs_err_in || rx_len_err_in;
    assign is_m  = rx_dest_in == mse_pkg::MSE_DEST_MCAST;
    assign is_b  = rx_dest_in == mse_pkg::MSE_DEST_BCAST;
    assign is_u  = !is_m && !is_b;

    assign rf.done        = rx_done_in;
    assign rf.frame_len   = rx_frame_len_in;
    assign rf.payload_len = rx_payload_len_in;
    assign rf.fcs_err     = rx_fcs_err_in;
    assign rf.len_err     = rx_len_err_in;
    assign rf.oversize    = over;
    assign rf.undersize   = under;

    always_comb begin
        bin_d = 6'h00;
        if (rx_frame_len_in == `MSE_MIN_FRAME_LEN) begin
            bin_d = 6'h01;
        end else if (rx_frame_len_in > `MSE_MIN_FRAME_LEN && rx_frame_len_in <= `MSE_BIN_127_LEN) begin
            bin_d = 6'h02;
        end else if (rx_frame_len_in > `MSE_BIN_127_LEN && rx_frame_len_in <= `MSE_BIN_255_LEN) begin
            bin_d = 6'h04;
        end else if (rx_frame_len_in > `MSE_BIN_255_LEN && rx_frame_len_in <= `MSE_BIN_511_LEN) begin
            bin_d = 6'h08;
        end else if (rx_frame_len_in > `MSE_BIN_511_LEN && rx_frame_len_in <= `MSE_BIN_1023_LEN) begin
            bin_d = 6'h10;
        end else if (rx_frame_len_in > `MSE_BIN_1023_LEN && rx_frame_len_in <= `MSE_BIN_1518_LEN) begin
            bin_d = 6'h20;
        end
    end

    // size classification pulses
    always_ff @(posedge clk_rxmac_in or negedge rst_rx_n_in) begin
        if (!rst_rx_n_in) begin
            rx_inc_runt_out <= 1'b0;
            rx_inc_bin_out  <= 6'h00;
            rx_inc_max_out  <= 1'b0;
            rx_inc_over_out <= 1'b0;
        end else begin
            rx_inc_runt_out <= rx_done_in && under;
            rx_inc_bin_out  <= rx_done_in ? bin_d : 6'h00;
            rx_inc_max_out  <= rx_done_in && rx_frame_len_in == rx_max_size_in;
            rx_inc_over_out <= rx_done_in && over;
        end
    end

    // destination class pulses for data and control frames
    always_ff @(posedge clk_rxmac_in or negedge rst_rx_n_in) begin
        if (!rst_rx_n_in) begin
            rx_inc_mcast_data_err_out <= 1'b0;
            rx_inc_bcast_data_err_out <= 1'b0;
            rx_inc_ucast_data_err_out <= 1'b0;
            rx_inc_mcast_data_ok_out  <= 1'b0;
            rx_inc_bcast_data_ok_out  <= 1'b0;
            rx_inc_ucast_data_ok_out  <= 1'b0;
            rx_inc_mcast_ctrl_out     <= 1'b0;
            rx_inc_bcast_ctrl_out     <= 1'b0;
            rx_inc_ucast_ctrl_out     <= 1'b0;
            rx_inc_mcast_ctrl_err_out <= 1'b0;
            rx_inc_bcast_ctrl_err_out <= 1'b0;
            rx_inc_ucast_ctrl_err_out <= 1'b0;
        end else begin
            rx_inc_mcast_data_err_out <= rx_done_in && !rx_ctrl_in && bad && is_m;
            rx_inc_bcast_data_err_out <= rx_done_in && !rx_ctrl_in && bad && is_b;
            rx_inc_ucast_data_err_out <= rx_done_in && !rx_ctrl_in && bad && is_u;
            rx_inc_mcast_data_ok_out  <= rx_done_in && !rx_ctrl_in && !bad && is_m;
            rx_inc_bcast_data_ok_out  <= rx_done_in && !rx_ctrl_in && !bad && is_b;
            rx_inc_ucast_data_ok_out  <= rx_done_in && !rx_ctrl_in && !bad && is_u;
            rx_inc_mcast_ctrl_out     <= rx_done_in && rx_ctrl_in && !bad && is_m;
            rx_inc_bcast_ctrl_out     <= rx_done_in && rx_ctrl_in && !bad && is_b;
            rx_inc_ucast_ctrl_out     <= rx_done_in && rx_ctrl_in && !bad && is_u;
            rx_inc_mcast_ctrl_err_out <= rx_done_in && rx_ctrl_in && bad && is_m;
            rx_inc_bcast_ctrl_err_out <= rx_done_in && rx_ctrl_in && bad && is_b;
            rx_inc_ucast_ctrl_err_out <= rx_done_in && rx_ctrl_in && bad && is_u;
        end
    end

    // pause and checksum error pulses
    always_ff @(posedge clk_rxmac_in or negedge rst_rx_n_in) begin
        if (!rst_rx_n_in) begin
            rx_inc_pause_out          <= 1'b0;
            rx_inc_pause_ctrl_err_out <= 1'b0;
            rx_inc_fcs_err_out        <= 1'b0;
            rx_inc_fragment_out       <= 1'b0;
            rx_inc_jabber_out         <= 1'b0;
            rx_inc_sizeok_fcserr_out  <= 1'b0;
        end else begin
            rx_inc_pause_out          <= rx_done_in && rx_pause_in && !bad;
            rx_inc_pause_ctrl_err_out <= rx_done_in && rx_pause_in && bad;
            rx_inc_fcs_err_out        <= rx_done_in && rx_fcs_err_in;
            rx_inc_fragment_out       <= rx_done_in && under && rx_fcs_err_in;
            rx_inc_jabber_out         <= rx_done_in && over && rx_fcs_err_in;
            rx_inc_sizeok_fcserr_out  <= rx_done_in && rx_fcs_err_in && !over && !under;
        end
    end

    // payload count always built, on the rx clock
    mse_octet_counter #(.TOTAL_W(64)) u_rx_oct (
        .clk_in     (clk_rxmac_in),
        .rst_n_in   (rst_rx_n_in),
        .frm        (rf.dst),
        .bytes_out  (rx_frame_payload_bytes_out),
        .strobe_out (rx_frame_payload_strobe_out),
        .total_out  (rx_payload_total_counter_out)
    );
endmodule : mse_stats_events
`default_nettype wire

// ==== test/mse_stats_events_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module mse_stats_events_assertions (
    input wire logic        clk_rxmac_in,
    input wire logic        rst_rx_n_in,
    input wire logic        rx_done_in,
    input wire logic [15:0] rx_frame_len_in,
    input wire logic        rx_fcs_err_in,
    input wire logic        rx_len_err_in,
    input wire logic [15:0] rx_max_size_in,
    input wire logic [5:0]  rx_inc_bin_out,
    input wire logic        rx_inc_max_out,
    input wire logic        rx_inc_over_out,
    input wire logic        rx_inc_fcs_err_out,
    input wire logic        rx_inc_fragment_out,
    input wire logic        rx_inc_jabber_out,
    input wire logic        rx_frame_payload_strobe_out
);
    wire under_w = rx_frame_len_in < 16'h0040;
    wire over_w  = rx_frame_len_in > rx_max_size_in;
    default clocking cb @(posedge clk_rxmac_in); endclocking
    default disable iff (!rst_rx_n_in);
    AST_BIN_64: assert property (rx_done_in && rx_frame_len_in == 16'h0040 |=> rx_inc_bin_out == 6'h01)
        else $error("bin wrong for 64 byte frame");
    AST_BIN_ONE: assert property (rx_done_in && !under_w && rx_frame_len_in <= 16'h05EE |=> $onehot(rx_inc_bin_out))
        else $error("bin not one-hot");
    AST_MAX: assert property (rx_done_in |=> rx_inc_max_out == ($past(rx_frame_len_in) == $past(rx_max_size_in)))
        else $error("max pulse wrong");
    AST_OVER: assert property (rx_done_in |=> rx_inc_over_out == $past(over_w))
        else $error("over pulse wrong");
    AST_FCS: assert property (rx_done_in |=> rx_inc_fcs_err_out == $past(rx_fcs_err_in))
        else $error("fcs pulse wrong");
    AST_FRAG: assert property (rx_done_in && rx_fcs_err_in && under_w |=> rx_inc_fragment_out)
        else $error("fragment pulse missing");
    AST_JAB: assert property (rx_done_in && rx_fcs_err_in && over_w |=> rx_inc_jabber_out)
        else $error("jabber pulse missing");
    AST_NO_STRB: assert property (rx_done_in && (rx_fcs_err_in || rx_len_err_in || under_w || over_w)
        |=> !rx_frame_payload_strobe_out)
        else $error("strobe on errored frame");
    AST_IDLE: assert property (!rx_done_in |=> rx_inc_bin_out == 6'h00 && !rx_frame_payload_strobe_out)
        else $error("pulse without frame");
    cover property (rx_done_in && rx_fcs_err_in && over_w);
    cover property (rx_frame_payload_strobe_out);
    cover property (rx_inc_max_out);
endmodule : mse_stats_events_assertions
`default_nettype wire

// ==== test/mse_stats_sink.sv ====
`timescale 1ns/10ps
`default_nettype none
module mse_stats_sink (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        strobe_in,
    input  wire logic [15:0] bytes_in,
    output logic [63:0]      sum_out
);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sum_out <= 64'h0;
        end else if (strobe_in) begin
            sum_out <= sum_out + {48'h0, bytes_in};
        end
    end
endmodule : mse_stats_sink
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        rd, rf, rl, rc, rp, td, tf, tl, tsz, tstb, rstb, rmo, rov, rfcs, rfrg, rjab, rsz, rpau, rpe, rrunt;
    logic [1:0]  rdest;
    logic [2:0]  dok, derr, ctl, cerr;
    logic [5:0]  rbin;
    logic [15:0] rlen, rpay, rmax, tlen, tpay, tmax, tbytes, rbytes;
    logic [63:0] ttot, rtot, sink_sum, rx_sum, tx_sum;
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc = 0;
    always #2.5 clk = ~clk;
    mse_stats_events uut (.clk_rxmac_in(clk), .rst_rx_n_in(rst_n), .clk_txmac_in(clk), .rst_tx_n_in(rst_n),
        .rx_done_in(rd), .rx_frame_len_in(rlen), .rx_payload_len_in(rpay), .rx_fcs_err_in(rf), .rx_len_err_in(rl),
        .rx_ctrl_in(rc), .rx_pause_in(rp), .rx_dest_in(rdest), .rx_max_size_in(rmax), .tx_done_in(td),
        .tx_frame_len_in(tlen), .tx_payload_len_in(tpay), .tx_fcs_err_in(tf), .tx_len_err_in(tl),
        .tx_max_size_in(tmax), .tx_inc_sizeok_fcserr_out(tsz), .tx_frame_payload_bytes_out(tbytes),
        .tx_frame_payload_strobe_out(tstb), .tx_payload_total_counter_out(ttot), .rx_inc_runt_out(rrunt),
        .rx_inc_bin_out(rbin), .rx_inc_max_out(rmo), .rx_inc_over_out(rov), .rx_inc_mcast_data_err_out(derr[2]),
        .rx_inc_mcast_data_ok_out(dok[2]), .rx_inc_bcast_data_err_out(derr[1]), .rx_inc_bcast_data_ok_out(dok[1]),
        .rx_inc_ucast_data_err_out(derr[0]), .rx_inc_ucast_data_ok_out(dok[0]), .rx_inc_mcast_ctrl_out(ctl[2]),
        .rx_inc_bcast_ctrl_out(ctl[1]), .rx_inc_ucast_ctrl_out(ctl[0]), .rx_inc_pause_out(rpau),
        .rx_inc_fcs_err_out(rfcs), .rx_inc_fragment_out(rfrg), .rx_inc_jabber_out(rjab),
        .rx_inc_sizeok_fcserr_out(rsz), .rx_inc_pause_ctrl_err_out(rpe), .rx_inc_mcast_ctrl_err_out(cerr[2]),
        .rx_inc_bcast_ctrl_err_out(cerr[1]), .rx_inc_ucast_ctrl_err_out(cerr[0]),
        .rx_frame_payload_bytes_out(rbytes), .rx_frame_payload_strobe_out(rstb), .rx_payload_total_counter_out(rtot));
    mse_stats_sink sink (.clk_in(clk), .rst_n_in(rst_n), .strobe_in(rstb), .bytes_in(rbytes), .sum_out(sink_sum));
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic rx_frame(input logic [15:0] len, pay, input logic fcs, lerr, ctrl, input logic [1:0] dest);
        logic       bad, und, ovr, strb, pse;
        logic [2:0] cls;
        logic [5:0] bin;
        bad = fcs | lerr;
        und = len < 16'h0040;
        ovr = len > rmax;
        strb = !bad && !und && !ovr;
        // minimum-size control frames are sent as pause frames, larger ones as other control frames
        pse = ctrl && len == 16'h0040;
        cls = (dest == 2'h1) ? 3'h4 : (dest == 2'h2) ? 3'h2 : 3'h1;
        bin = (len == 16'h0040) ? 6'h01 : (und || len > 16'h05EE) ? 6'h00 : (len < 16'h0080) ? 6'h02 :
            (len < 16'h0100) ? 6'h04 : (len < 16'h0200) ? 6'h08 : (len < 16'h0400) ? 6'h10 : 6'h20;
        @(posedge clk);
        #1;
        {rd, rlen, rpay, rf, rl, rc, rp, rdest} = {1'b1, len, pay, fcs, lerr, ctrl, pse, dest};
        @(posedge clk);
        #1;
        rd = 1'b0;
        chk("runt", rrunt, und);
        chk("bin", rbin, bin);
        chk("max", rmo, len == rmax);
        chk("over", rov, ovr);
        chk("data_err", derr, (!ctrl && bad) ? cls : 3'h0);
        chk("data_ok", dok, (!ctrl && !bad) ? cls : 3'h0);
        chk("ctrl", ctl, (ctrl && !bad) ? cls : 3'h0);
        chk("pause", rpau, pse && !bad);
        chk("fcs", rfcs, fcs);
        chk("fragment", rfrg, fcs && und);
        chk("jabber", rjab, fcs && ovr);
        chk("sizeok", rsz, fcs && !und && !ovr);
        chk("pause_err", rpe, pse && bad);
        chk("ctrl_err", cerr, (ctrl && bad) ? cls : 3'h0);
        chk("strobe", rstb, strb);
        if (strb) chk("bytes", rbytes, pay);
        if (strb) rx_sum += pay;
        chk("total", rtot, rx_sum);
    endtask : rx_frame
    task automatic tx_frame(input logic [15:0] len, pay, input logic fcs, lerr);
        logic strb;
        strb = !fcs && !lerr && len >= 16'h0040 && len <= tmax;
        @(posedge clk);
        #1;
        {td, tlen, tpay, tf, tl} = {1'b1, len, pay, fcs, lerr};
        @(posedge clk);
        #1;
        td = 1'b0;
        chk("tx_sizeok", tsz, fcs && len >= 16'h0040 && len <= tmax);
        chk("tx_strobe", tstb, strb);
        if (strb) chk("tx_bytes", tbytes, pay);
        if (strb) tx_sum += pay;
        chk("tx_total", ttot, tx_sum);
    endtask : tx_frame
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        {rd, rf, rl, rc, rp, td, tf, tl, rdest} = 10'h000;
        {rlen, rpay, tlen, tpay, rx_sum, tx_sum} = 192'h0;
        {rmax, tmax} = {16'h05EE, 16'h05EE};
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rx_frame(16'h0040, 16'h002E, 1'b0, 1'b0, 1'b0, 2'h0);
        rx_frame(16'h0064, 16'h0052, 1'b0, 1'b0, 1'b0, 2'h1);
        rx_frame(16'h00C8, 16'h00AA, 1'b0, 1'b0, 1'b0, 2'h2);
        rx_frame(16'h012C, 16'h010E, 1'b1, 1'b0, 1'b0, 2'h3);
        rx_frame(16'h0258, 16'h023A, 1'b0, 1'b1, 1'b0, 2'h1);
        rx_frame(16'h05EE, 16'h05D0, 1'b0, 1'b0, 1'b0, 2'h2);
        rx_frame(16'h05EF, 16'h05D1, 1'b0, 1'b0, 1'b0, 2'h0);
        rx_frame(16'h0640, 16'h0622, 1'b1, 1'b0, 1'b0, 2'h0);
        rx_frame(16'h0028, 16'h000A, 1'b1, 1'b0, 1'b0, 2'h1);
        rx_frame(16'h003C, 16'h001E, 1'b0, 1'b0, 1'b0, 2'h0);
        rx_frame(16'h0040, 16'h002E, 1'b0, 1'b0, 1'b1, 2'h1);
        rx_frame(16'h0040, 16'h002E, 1'b1, 1'b0, 1'b1, 2'h2);
        rx_frame(16'h0400, 16'h03E2, 1'b0, 1'b1, 1'b1, 2'h0);
        $display("test rx_classes done");
        rmax = 16'h03E8;
        rx_frame(16'h03E8, 16'h03CA, 1'b0, 1'b0, 1'b0, 2'h0);
        rx_frame(16'h03E9, 16'h03CB, 1'b0, 1'b0, 1'b0, 2'h0);
        @(posedge clk);
        #1;
        chk("sink_sum", sink_sum, rx_sum);
        $display("test rx_max_size done");
        tx_frame(16'h0080, 16'h0062, 1'b0, 1'b0);
        tx_frame(16'h0080, 16'h0062, 1'b1, 1'b0);
        tx_frame(16'h003F, 16'h0021, 1'b1, 1'b0);
        tx_frame(16'h05EF, 16'h05D1, 1'b1, 1'b0);
        tx_frame(16'h05EE, 16'h05D0, 1'b0, 1'b1);
        $display("test tx_frames done");
        {rst_n, rd, rlen} = {1'b0, 1'b1, 16'h0040};
        @(posedge clk);
        #1;
        chk("rst_pulses", {rbin, rstb, rfcs, tstb, tsz, rrunt}, 11'h000);
        chk("rst_totals", rtot | ttot, 64'h0);
        {rst_n, rd, rx_sum, tx_sum} = {1'b1, 1'b0, 128'h0};
        rx_frame(16'h0041, 16'h0023, 1'b0, 1'b0, 1'b0, 2'h1);
        $display("test reset done");
        report_and_stop();
    end
endmodule : tb
bind mse_stats_events mse_stats_events_assertions u_chk (.clk_rxmac_in(clk_rxmac_in), .rst_rx_n_in(rst_rx_n_in),
    .rx_done_in(rx_done_in), .rx_frame_len_in(rx_frame_len_in), .rx_fcs_err_in(rx_fcs_err_in),
    .rx_len_err_in(rx_len_err_in), .rx_max_size_in(rx_max_size_in), .rx_inc_bin_out(rx_inc_bin_out),
    .rx_inc_max_out(rx_inc_max_out), .rx_inc_over_out(rx_inc_over_out), .rx_inc_fcs_err_out(rx_inc_fcs_err_out),
    .rx_inc_fragment_out(rx_inc_fragment_out), .rx_inc_jabber_out(rx_inc_jabber_out),
    .rx_frame_payload_strobe_out(rx_frame_payload_strobe_out));
`default_nettype wire
